/* File: include/cpu_regs_pkg.sv */
package cpu_regs_pkg;

    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;

    // Software register offsets
    localparam logic [3:0] OFF_IP = 4'h0;
    localparam logic [3:0] OFF_ACC = 4'h1;
    localparam logic [3:0] OFF_TMP = 4'h2;
    localparam logic [3:0] OFF_IDX = 4'h3;
    localparam logic [3:0] OFF_EXT = 4'h4;
    localparam logic [3:0] OFF_STK = 4'h5;
    localparam logic [3:0] OFF_PSW = 4'h6;
    localparam logic [3:0] OFF_BANK = 4'h7;
    localparam logic [3:0] OFF_STAT = 4'h8;

    // Condition flag positions within the low byte
    localparam int BIT_C = 0;
    localparam int BIT_V = 1;
    localparam int BIT_Z = 2;
    localparam int BIT_N = 3;
    localparam int BIT_IL_LO = 4;
    localparam int BIT_IL_HI = 5;
    localparam int BIT_I = 6;
    localparam int BIT_H = 7;

    // Bank select field in the upper byte
    localparam int BANK_HI = 15;
    localparam int BANK_LO = 11;
    localparam int BANK_W = 5;
    localparam int GPR_IDX_W = 3;

    localparam logic [1:0] IL_NONE = 2'b11;

    // Reset values
    localparam logic [15:0] IP_RST = 16'h0000;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [15:0] PSW_RST = 16'h0030;

    // Memory map
    localparam logic [15:0] RAM_BASE = 16'h0100;
    localparam logic [15:0] IO_TOP = 16'h0080;
    localparam logic [15:0] PROG_BASE = 16'h8000;
    localparam logic [15:0] IP_STEP = 16'h0001;

    typedef enum logic [2:0] {
        SEL_IP = 3'b000,
        SEL_ACC = 3'b001,
        SEL_TMP = 3'b010,
        SEL_IDX = 3'b011,
        SEL_EXT = 3'b100,
        SEL_STK = 3'b101,
        SEL_PSW = 3'b110,
        SEL_NONE = 3'b111
    } reg_sel_e;

    typedef enum logic [1:0] {
        REGION_IO = 2'b00,
        REGION_DATA = 2'b01,
        REGION_PROG = 2'b10
    } region_e;

endpackage

/* File: include/alu_flags_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface alu_flags_if;
    logic [15:0] opa;
    logic [15:0] opb;
    logic sub;
    logic word;
    logic [15:0] res;
    logic half;
    logic carry;
    logic ovf;
    logic neg;
    logic zero;
    modport core (output opa, output opb, output sub, output word,
        input res, input half, input carry, input ovf, input neg, input zero);
    modport unit (input opa, input opb, input sub, input word,
        output res, output half, output carry, output ovf, output neg, output zero);
endinterface
`default_nettype wire

/* File: hdl/alu_flag_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module alu_flag_unit (
    alu_flags_if.unit fl
);
    logic [15:0] b_eff;
    logic [4:0] nib_sum;
    logic [8:0] byte_sum;
    logic [16:0] word_sum;

    always_comb begin
        b_eff = fl.sub ? ~fl.opb : fl.opb;
        nib_sum = {1'b0, fl.opa[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, fl.sub};
        byte_sum = {1'b0, fl.opa[7:0]} + {1'b0, b_eff[7:0]} + {8'h00, fl.sub};
        word_sum = {1'b0, fl.opa} + {1'b0, b_eff} + {16'h0000, fl.sub};
    end

    always_comb begin
        // Borrow is the inverted carry when subtracting
        fl.half = nib_sum[4] ^ fl.sub;
        if (fl.word) begin
            fl.res = word_sum[15:0];
            fl.carry = word_sum[16] ^ fl.sub;
            fl.neg = word_sum[15];
            fl.zero = (word_sum[15:0] == 16'h0000);
            fl.ovf = (fl.opa[15] == b_eff[15]) && (word_sum[15] != fl.opa[15]);
        end else begin
            fl.res = {8'h00, byte_sum[7:0]};
            fl.carry = byte_sum[8] ^ fl.sub;
            fl.neg = byte_sum[7];
            fl.zero = (byte_sum[7:0] == 8'h00);
            fl.ovf = (fl.opa[7] == b_eff[7]) && (byte_sum[7] != fl.opa[7]);
        end
    end
endmodule
`default_nettype wire

/* File: hdl/cpu_status_regs.sv */
// Summary of operation
// RULE1: A 16-bit instruction pointer marks the instruction being fetched.
// RULE2: A 16-bit accumulator holds results; byte operations use only its low byte.
// RULE3: A 16-bit temporary accumulator is the second operand; byte operations use low byte.
// RULE4: Index pointer, extra pointer and stack top pointer are 16-bit registers.
// RULE5: Status word holds bank select high byte and condition flags low byte.
// RULE6: Bank select chooses the memory address of the active register bank.
// RULE7: Half-carry flag follows carry or borrow between bits 3 and 4.
// RULE8: Interrupt enable flag permits interrupts when 1; reset clears it.
// RULE9: Interrupt level admits only higher priority requests; level 3 admits none.
// RULE10: Negative flag copies the most significant result bit.
// RULE11: Zero flag is set only for a zero result.
// RULE12: Overflow flag shows two's-complement overflow of the result.
// RULE13: Carry flag follows carry or borrow from bit 7; shifts load shifted-out bit.
// RULE14: Eight 8-bit general registers per bank in memory, up to 32 banks.
// RULE15: One 64 KB space: I/O lowest, data above, program at the top.
// RULE16: Bank base is fixed RAM base plus bank number times eight.
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module cpu_status_regs
    import cpu_regs_pkg::*;
#(
    parameter int BANK_COUNT = 32,
    parameter logic [15:0] RAM_BASE_ADDR = RAM_BASE,
    parameter logic [15:0] IO_LIMIT = IO_TOP,
    parameter logic [15:0] PROG_START = PROG_BASE
) (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [DATA_W-1:0] reg_rdata_out,
    input wire logic ip_inc_in,
    input wire logic ld_valid_in,
    input wire reg_sel_e ld_sel_in,
    input wire logic [DATA_W-1:0] ld_data_in,
    input wire logic alu_valid_in,
    input wire logic alu_sub_in,
    input wire logic alu_word_in,
    input wire logic shift_valid_in,
    input wire logic shift_out_bit_in,
    input wire logic [DATA_W-1:0] shift_result_in,
    input wire logic [GPR_IDX_W-1:0] gpr_index_in,
    input wire logic irq_req_in,
    input wire logic [1:0] irq_level_in,
    input wire logic [DATA_W-1:0] access_addr_in,
    output logic [DATA_W-1:0] instruction_pointer_out,
    output logic [DATA_W-1:0] accum_out,
    output logic [DATA_W-1:0] temp_accum_out,
    output logic [DATA_W-1:0] index_pointer_out,
    output logic [DATA_W-1:0] extra_pointer_out,
    output logic [DATA_W-1:0] stack_top_pointer_out,
    output logic [DATA_W-1:0] program_status_word_out,
    output logic [DATA_W-1:0] gpr_addr_out,
    output logic irq_accept_out,
    output logic [1:0] mem_region_out
);

    localparam logic [BANK_W-1:0] BANK_MASK = BANK_W'(BANK_COUNT - 1);

    logic [15:0] instruction_pointer_r;
    logic [15:0] accum_r;
    logic [15:0] temp_accum_r;
    logic [15:0] index_pointer_r;
    logic [15:0] extra_pointer_r;
    logic [15:0] stack_top_pointer_r;
    logic [15:0] program_status_word_r;
    logic [15:0] gpr_addr_r;
    logic [15:0] rd_data_r;
    logic irq_accept_r;
    logic [1:0] region_r;

    logic sw_wr_ip;
    logic sw_wr_acc;
    logic sw_wr_tmp;
    logic sw_wr_idx;
    logic sw_wr_ext;
    logic sw_wr_stk;
    logic sw_wr_psw;
    logic [BANK_W-1:0] bank_num;
    logic [1:0] il_cur;
    logic [15:0] gpr_addr_nxt;
    logic irq_accept_nxt;
    region_e region_nxt;

    alu_flags_if fl ();

    // Byte or word operation of accumulator with temporary accumulator
    assign fl.opa = accum_r;
    assign fl.opb = temp_accum_r;
    assign fl.sub = alu_sub_in;
    assign fl.word = alu_word_in;

    alu_flag_unit u_alu (
        .fl(fl)
    );

    assign sw_wr_ip = reg_wr_in && (reg_addr_in == OFF_IP);
    assign sw_wr_acc = reg_wr_in && (reg_addr_in == OFF_ACC);
    assign sw_wr_tmp = reg_wr_in && (reg_addr_in == OFF_TMP);
    assign sw_wr_idx = reg_wr_in && (reg_addr_in == OFF_IDX);
    assign sw_wr_ext = reg_wr_in && (reg_addr_in == OFF_EXT);
    assign sw_wr_stk = reg_wr_in && (reg_addr_in == OFF_STK);
    assign sw_wr_psw = reg_wr_in && (reg_addr_in == OFF_PSW);

    // RULE1: instruction pointer update
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            instruction_pointer_r <= IP_RST;
        end else if (ld_valid_in && ld_sel_in == SEL_IP) begin
            instruction_pointer_r <= ld_data_in;
        end else if (sw_wr_ip) begin
            instruction_pointer_r <= reg_wdata_in;
        end else if (ip_inc_in) begin
            instruction_pointer_r <= instruction_pointer_r + IP_STEP;
        end
    end

    // RULE2: accumulator with byte-wide writeback
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            accum_r <= WORD_RST;
        end else if (ld_valid_in && ld_sel_in == SEL_ACC) begin
            accum_r <= ld_data_in;
        end else if (sw_wr_acc) begin
            accum_r <= reg_wdata_in;
        end else if (alu_valid_in) begin
            if (alu_word_in) begin
                accum_r <= fl.res;
            end else begin
                accum_r[7:0] <= fl.res[7:0];
            end
        end else if (shift_valid_in) begin
            accum_r <= shift_result_in;
        end
    end

    // RULE3: temporary accumulator
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            temp_accum_r <= WORD_RST;
        end else if (ld_valid_in && ld_sel_in == SEL_TMP) begin
            temp_accum_r <= ld_data_in;
        end else if (sw_wr_tmp) begin
            temp_accum_r <= reg_wdata_in;
        end
    end

    // RULE4: pointer registers
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            index_pointer_r <= WORD_RST;
            extra_pointer_r <= WORD_RST;
            stack_top_pointer_r <= WORD_RST;
        end else begin
            if (ld_valid_in && ld_sel_in == SEL_IDX) begin
                index_pointer_r <= ld_data_in;
            end else if (sw_wr_idx) begin
                index_pointer_r <= reg_wdata_in;
            end
            if (ld_valid_in && ld_sel_in == SEL_EXT) begin
                extra_pointer_r <= ld_data_in;
            end else if (sw_wr_ext) begin
                extra_pointer_r <= reg_wdata_in;
            end
            if (ld_valid_in && ld_sel_in == SEL_STK) begin
                stack_top_pointer_r <= ld_data_in;
            end else if (sw_wr_stk) begin
                stack_top_pointer_r <= reg_wdata_in;
            end
        end
    end

    // RULE5: status word, bank select high byte, flags low byte
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            // RULE8: interrupt enable cleared at reset
            program_status_word_r <= PSW_RST;
        end else if (ld_valid_in && ld_sel_in == SEL_PSW) begin
            program_status_word_r <= ld_data_in;
        end else if (sw_wr_psw) begin
            program_status_word_r <= reg_wdata_in;
        end else if (alu_valid_in) begin
            // RULE7: half carry
            program_status_word_r[BIT_H] <= fl.half;
            // RULE10: negative flag
            program_status_word_r[BIT_N] <= fl.neg;
            // RULE11: zero flag
            program_status_word_r[BIT_Z] <= fl.zero;
            // RULE12: overflow flag
            program_status_word_r[BIT_V] <= fl.ovf;
            // RULE13: carry from bit 7, or from bit 15 in word operations
            program_status_word_r[BIT_C] <= fl.carry;
        end else if (shift_valid_in) begin
            // RULE13: shifted-out bit
            program_status_word_r[BIT_C] <= shift_out_bit_in;
        end
    end

    // RULE14: bank number limited to available banks
    assign bank_num = program_status_word_r[BANK_HI:BANK_LO] & BANK_MASK;
    assign il_cur = program_status_word_r[BIT_IL_HI:BIT_IL_LO];

    // RULE16: bank base plus register index
    assign gpr_addr_nxt = RAM_BASE_ADDR + {8'h00, bank_num, 3'b000} + {13'h0000, gpr_index_in};

    // RULE6: active bank register address
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            gpr_addr_r <= RAM_BASE_ADDR;
        end else begin
            gpr_addr_r <= gpr_addr_nxt;
        end
    end

    // RULE9: level gate, level 3 admits none
    assign irq_accept_nxt = irq_req_in && program_status_word_r[BIT_I]
        && (il_cur != IL_NONE) && (irq_level_in < il_cur);

    // RULE8: enable flag gates requests
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            irq_accept_r <= 1'b0;
        end else begin
            irq_accept_r <= irq_accept_nxt;
        end
    end

    // RULE15: address space regions
    always_comb begin
        if (access_addr_in < IO_LIMIT) begin
            region_nxt = REGION_IO;
        end else if (access_addr_in < PROG_START) begin
            region_nxt = REGION_DATA;
        end else begin
            region_nxt = REGION_PROG;
        end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            region_r <= REGION_IO;
        end else begin
            region_r <= region_nxt;
        end
    end

    // Software read port, data in the next cycle
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rd_data_r <= WORD_RST;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                OFF_IP: rd_data_r <= instruction_pointer_r;
                OFF_ACC: rd_data_r <= accum_r;
                OFF_TMP: rd_data_r <= temp_accum_r;
                OFF_IDX: rd_data_r <= index_pointer_r;
                OFF_EXT: rd_data_r <= extra_pointer_r;
                OFF_STK: rd_data_r <= stack_top_pointer_r;
                OFF_PSW: rd_data_r <= program_status_word_r;
                OFF_BANK: rd_data_r <= gpr_addr_r;
                OFF_STAT: rd_data_r <= {13'h0000, irq_accept_r, region_r};
                default: rd_data_r <= WORD_RST;
            endcase
        end else begin
            rd_data_r <= WORD_RST;
        end
    end

    assign reg_rdata_out = rd_data_r;
    assign instruction_pointer_out = instruction_pointer_r;
    assign accum_out = accum_r;
    assign temp_accum_out = temp_accum_r;
    assign index_pointer_out = index_pointer_r;
    assign extra_pointer_out = extra_pointer_r;
    assign stack_top_pointer_out = stack_top_pointer_r;
    assign program_status_word_out = program_status_word_r;
    assign gpr_addr_out = gpr_addr_r;
    assign irq_accept_out = irq_accept_r;
    assign mem_region_out = region_r;

    logic plain_alu;
    assign plain_alu = alu_valid_in && !reg_wr_in && !ld_valid_in;

    a_ip_advance: assert property ( // RULE1
        @(posedge mclk_in) disable iff (sys_rst_in)
        ip_inc_in && !reg_wr_in && !ld_valid_in
        |=> instruction_pointer_r == $past(instruction_pointer_r) + IP_STEP)
        else $error("instruction pointer did not advance");

    a_acc_upper_kept: assert property ( // RULE2
        @(posedge mclk_in) disable iff (sys_rst_in)
        plain_alu && !alu_word_in |=> accum_r[15:8] == $past(accum_r[15:8]))
        else $error("byte operation changed accumulator high byte");

    a_zero_flag_byte: assert property ( // RULE11
        @(posedge mclk_in) disable iff (sys_rst_in)
        plain_alu && !alu_word_in
        |=> program_status_word_r[BIT_Z] == (accum_r[7:0] == 8'h00))
        else $error("zero flag disagrees with result");

    a_neg_flag_word: assert property ( // RULE10
        @(posedge mclk_in) disable iff (sys_rst_in)
        plain_alu && alu_word_in |=> program_status_word_r[BIT_N] == accum_r[15])
        else $error("negative flag disagrees with result");

    a_shift_carry: assert property ( // RULE13
        @(posedge mclk_in) disable iff (sys_rst_in)
        shift_valid_in && !alu_valid_in && !reg_wr_in && !ld_valid_in
        |=> program_status_word_r[BIT_C] == $past(shift_out_bit_in))
        else $error("carry did not take shifted-out bit");

    a_irq_enable_gate: assert property ( // RULE8
        @(posedge mclk_in) disable iff (sys_rst_in)
        irq_accept_out |-> $past(program_status_word_r[BIT_I] && irq_req_in))
        else $error("interrupt accepted while disabled");

    a_irq_level_none: assert property ( // RULE9
        @(posedge mclk_in) disable iff (sys_rst_in)
        $past(il_cur) == IL_NONE |-> !irq_accept_out)
        else $error("interrupt accepted at lowest level");

    a_bank_address: assert property ( // RULE16
        @(posedge mclk_in) disable iff (sys_rst_in)
        ##1 gpr_addr_out == RAM_BASE_ADDR + {8'h00, $past(bank_num), 3'b000}
            + {13'h0000, $past(gpr_index_in)})
        else $error("register bank address wrong");

    a_read_stack: assert property ( // RULE4
        @(posedge mclk_in) disable iff (sys_rst_in)
        reg_rd_in && reg_addr_in == OFF_STK
        |=> reg_rdata_out == $past(stack_top_pointer_r) ##1 reg_rdata_out == WORD_RST || $past(reg_rd_in))
        else $error("stack pointer read wrong");

    a_half_carry_add: assert property ( // RULE7
        @(posedge mclk_in) disable iff (sys_rst_in)
        plain_alu && !alu_sub_in
        |=> program_status_word_r[BIT_H] == ({1'b0, $past(accum_r[3:0])} + {1'b0, $past(temp_accum_r[3:0])} > 5'h0f))
        else $error("half carry disagrees with operands");

endmodule
`default_nettype wire

/* File: test/exec_datapath_model.sv */
`timescale 1ns/1ps
`default_nettype none
module exec_datapath_model
    import cpu_regs_pkg::*;
(
    input wire logic mclk_in,
    output logic ip_inc_out,
    output logic ld_valid_out,
    output reg_sel_e ld_sel_out,
    output logic [DATA_W-1:0] ld_data_out,
    output logic alu_valid_out,
    output logic alu_sub_out,
    output logic alu_word_out,
    output logic shift_valid_out,
    output logic shift_bit_out,
    output logic [DATA_W-1:0] shift_result_out,
    output logic [GPR_IDX_W-1:0] gpr_index_out,
    output logic irq_req_out,
    output logic [1:0] irq_level_out,
    output logic [DATA_W-1:0] access_addr_out
);
    initial begin
        {ip_inc_out, ld_valid_out, alu_valid_out, alu_sub_out, alu_word_out} = 5'h00;
        {shift_valid_out, shift_bit_out, irq_req_out, irq_level_out} = 5'h00;
        ld_sel_out = SEL_NONE;
        ld_data_out = 16'h0000;
        shift_result_out = 16'h0000;
        gpr_index_out = 3'h0;
        access_addr_out = 16'h0000;
    end

    // Loads one register; the data bus shows junk once released
    task automatic load(input reg_sel_e sel, input logic [15:0] d);
        @(posedge mclk_in);
        ld_valid_out <= 1'b1;
        ld_sel_out <= sel;
        ld_data_out <= d;
        @(posedge mclk_in);
        ld_valid_out <= 1'b0;
        ld_sel_out <= SEL_NONE;
        ld_data_out <= ~d;
        #1;
    endtask

    task automatic alu(input logic sub, input logic word);
        @(posedge mclk_in);
        alu_valid_out <= 1'b1;
        alu_sub_out <= sub;
        alu_word_out <= word;
        @(posedge mclk_in);
        alu_valid_out <= 1'b0;
        alu_sub_out <= ~sub;
        alu_word_out <= ~word;
        #1;
    endtask

    task automatic shift(input logic [15:0] r, input logic b);
        @(posedge mclk_in);
        shift_valid_out <= 1'b1;
        shift_result_out <= r;
        shift_bit_out <= b;
        @(posedge mclk_in);
        shift_valid_out <= 1'b0;
        shift_result_out <= ~r;
        shift_bit_out <= ~b;
        #1;
    endtask

    task automatic step_ip(input int n);
        @(posedge mclk_in);
        ip_inc_out <= 1'b1;
        repeat (n) @(posedge mclk_in);
        ip_inc_out <= 1'b0;
        #1;
    endtask

    // Level inputs; returns just after the edge that takes them
    task automatic side(input logic req, input logic [1:0] lvl, input logic [2:0] idx, input logic [15:0] a);
        @(posedge mclk_in);
        irq_req_out <= req;
        irq_level_out <= lvl;
        gpr_index_out <= idx;
        access_addr_out <= a;
        @(posedge mclk_in);
        #1;
    endtask
endmodule
`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
    import cpu_regs_pkg::*;
;
    logic mclk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [3:0] bus_addr = 4'h0;
    logic [15:0] bus_wdata = 16'h0000;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [15:0] rdata, gpr_addr;
    wire [15:0] outs [0:6];
    logic [1:0] region;
    logic accept;
    logic ip_inc, ld_valid, alu_valid, alu_sub, alu_word, shift_valid, shift_bit, irq_req;
    reg_sel_e ld_sel;
    logic [15:0] ld_data, shift_result, access_addr, rd_val, wv;
    logic [2:0] gpr_index;
    logic [1:0] irq_level;
    logic [20:0] e;
    int num_errors = 0;
    int samples_checked = 0;
    logic [15:0] alu_tab [0:7][0:1] = '{'{16'h120f, 16'h0001}, '{16'h007f, 16'h0001}, '{16'h00ff, 16'h0001},
        '{16'h0000, 16'h0001}, '{16'h0080, 16'h0001}, '{16'h7fff, 16'h0001}, '{16'h0000, 16'h0001},
        '{16'hffff, 16'h0001}};
    logic [15:0] irq_tab [0:6] = '{16'h2860, 16'h2861, 16'h2862, 16'h2863, 16'h2840, 16'h2870, 16'h2820};

    always #12.5 mclk_in = ~mclk_in;

    cpu_status_regs DUT (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(bus_addr),
        .reg_wdata_in(bus_wdata), .reg_wr_in(bus_wr), .reg_rd_in(bus_rd), .reg_rdata_out(rdata),
        .ip_inc_in(ip_inc), .ld_valid_in(ld_valid), .ld_sel_in(ld_sel), .ld_data_in(ld_data),
        .alu_valid_in(alu_valid), .alu_sub_in(alu_sub), .alu_word_in(alu_word),
        .shift_valid_in(shift_valid), .shift_out_bit_in(shift_bit), .shift_result_in(shift_result),
        .gpr_index_in(gpr_index), .irq_req_in(irq_req), .irq_level_in(irq_level),
        .access_addr_in(access_addr), .instruction_pointer_out(outs[0]), .accum_out(outs[1]),
        .temp_accum_out(outs[2]), .index_pointer_out(outs[3]), .extra_pointer_out(outs[4]),
        .stack_top_pointer_out(outs[5]), .program_status_word_out(outs[6]), .gpr_addr_out(gpr_addr),
        .irq_accept_out(accept), .mem_region_out(region));

    exec_datapath_model far (.mclk_in(mclk_in), .ip_inc_out(ip_inc), .ld_valid_out(ld_valid),
        .ld_sel_out(ld_sel), .ld_data_out(ld_data), .alu_valid_out(alu_valid), .alu_sub_out(alu_sub),
        .alu_word_out(alu_word), .shift_valid_out(shift_valid), .shift_bit_out(shift_bit),
        .shift_result_out(shift_result), .gpr_index_out(gpr_index), .irq_req_out(irq_req),
        .irq_level_out(irq_level), .access_addr_out(access_addr));

    task automatic give_verdict();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge mclk_in);
        bus_wr <= 1'b0;
        bus_wdata <= ~d;
        #1;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk_in);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge mclk_in);
        bus_rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    // Result and {h,n,z,v,c} of an add or subtract, byte or word wide
    function automatic logic [20:0] alu_exp(input logic [15:0] a, b, input logic sub, word);
        logic [16:0] r;
        logic h, n, z, v, c;
        r = sub ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
        h = sub ? (a[3:0] < b[3:0]) : ({1'b0, a[3:0]} + {1'b0, b[3:0]} > 5'h0f);
        if (word) begin
            n = r[15];
            z = (r[15:0] == 16'h0000);
            c = r[16];
            v = sub ? (a[15] != b[15] && r[15] != a[15]) : (a[15] == b[15] && r[15] != a[15]);
            return {h, n, z, v, c, r[15:0]};
        end
        n = r[7];
        z = (r[7:0] == 8'h00);
        c = sub ? (a[7:0] < b[7:0]) : r[8] ^ a[8] ^ b[8];
        v = sub ? (a[7] != b[7] && r[7] != a[7]) : (a[7] == b[7] && r[7] != a[7]);
        return {h, n, z, v, c, a[15:8], r[7:0]};
    endfunction

    initial begin
        #(25 * 20000);
        num_errors++;
        give_verdict();
    end

    initial begin
        repeat (16) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        #1;
        for (int i = 0; i < 7; i++) begin
            rd(4'(i), rd_val);
            chk("reset value", (i == 6) ? PSW_RST : 16'h0000, rd_val);
        end
        chk("reset bank address", 16'h0100, gpr_addr);
        for (int i = 0; i < 6; i++) begin
            wv = 16'h1234 + 16'(i) * 16'h1111;
            wr(4'(i), wv);
            chk("register output", wv, outs[i]);
            rd(4'(i), rd_val);
            chk("register readback", wv, rd_val);
        end
        wr(OFF_PSW, 16'h2860);
        wr(OFF_STAT, 16'hffff);
        rd(OFF_PSW, rd_val);
        chk("status word", 16'h2860, rd_val);
        rd(4'hf, rd_val);
        chk("unmapped read", 16'h0000, rd_val);
        far.step_ip(3);
        chk("pointer advance", 16'h1237, outs[0]);
        far.side(1'b0, 2'h0, 3'h3, 16'h007f);
        chk("bank address", 16'h012b, gpr_addr);
        chk("region io", 16'(REGION_IO), 16'(region));
        for (int i = 0; i < 4; i++) begin
            far.side(1'b0, 2'h0, 3'h0, (i < 2) ? 16'h0080 + 16'(i) * 16'h7f7f : 16'h8000 + 16'(i - 2) * 16'h7fff);
            chk("region", (i < 2) ? 16'(REGION_DATA) : 16'(REGION_PROG), 16'(region));
        end
        for (int i = 0; i < 7; i++) begin
            wr(OFF_PSW, {irq_tab[i][15:2], 2'b00});
            far.side(1'b1, irq_tab[i][1:0], 3'h7, 16'h0000);
            chk("irq accept", {15'h0000, i < 2}, {15'h0000, accept});
            chk("bank address top", 16'h0100 + {11'h000, irq_tab[i][15:11]} * 16'h0008 + 16'h0007, gpr_addr);
        end
        far.side(1'b0, 2'h0, 3'h7, 16'h0000);
        wr(OFF_PSW, 16'hf870);
        #25;
        chk("last bank address", 16'h01ff, gpr_addr);
        for (int i = 0; i < 8; i++) begin
            far.load(SEL_ACC, alu_tab[i][0]);
            far.load(SEL_TMP, alu_tab[i][1]);
            far.alu(i inside {3, 4, 6}, i >= 5);
            e = alu_exp(alu_tab[i][0], alu_tab[i][1], i inside {3, 4, 6}, i >= 5);
            chk("alu result", e[15:0], outs[1]);
            chk("alu flags", {8'h00, e[20], 3'b111, e[19:16]},
                {8'h00, outs[6][BIT_H], outs[6][BIT_I:BIT_IL_LO], outs[6][BIT_N:BIT_C]});
        end
        far.shift(16'h8001, 1'b1);
        chk("shift carry set", 16'h8001, {outs[1][15:1], outs[6][BIT_C]});
        far.shift(16'h0002, 1'b0);
        chk("shift carry clear", 16'h0002, {outs[1][15:1], outs[6][BIT_C] | outs[1][0]});
        give_verdict();
    end
endmodule
`default_nettype wire
